// ===== common/exec_pkg.sv
// Constants, opcode patterns and types shared by the instruction execution block.
package exec_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	localparam int BANK_W = 4;
	// Operand bit positions inside the 16-bit opcode.
	localparam int DEST_BIT   = 9;
	localparam int ACCESS_BIT = 8;
	// Opcode patterns, matched on the upper opcode bits; sleep is matched on all 16 opcode bits.
	localparam logic [5:0]  ROT_RIGHT_CODE  = 6'h10;
	localparam logic [6:0]  SET_ONES_CODE   = 7'h34;
	localparam logic [5:0]  SUB_FWB_CODE    = 6'h15;
	localparam logic [5:0]  SUB_WF_CODE     = 6'h17;
	localparam logic [7:0]  SUB_LW_CODE     = 8'h08;
	localparam logic [15:0] SLEEP_CODE      = 16'h0003;
	localparam logic [15:0] NOP_CODE        = 16'h0000;
	// Data addressing.
	localparam logic [7:0] INDEX_LIMIT    = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT   = 8'h60;
	localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
	localparam logic [7:0] ALL_ONES       = 8'hFF;
	localparam logic [7:0] ZERO_BYTE      = 8'h00;
	// Reset values.
	localparam logic [7:0]  W_RESET       = 8'h00;
	localparam logic [4:0]  STATUS_RESET  = 5'h00;
	localparam logic        TIMEOUT_RESET = 1'b1;
	localparam logic        PD_RESET      = 1'b1;
	localparam logic [11:0] ADDR_RESET    = 12'h000;

	typedef struct packed
	{
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} status_type;

	typedef enum {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_type;

	typedef enum {OP_NONE, OP_ROT, OP_SET_FILE_ALL_ONES_OP, OP_SLEEP, OP_SUB_FILE_FROM_W_BORROW_OP, OP_SUB_W_FROM_LITERAL_OP, OP_SUB_W_FROM_FILE_OP} op_type;
endpackage

// ===== core/rot_set_sleep_sub_exec.sv
// Four-phase decode and execute unit for rotate, set, sleep and subtract instructions.
//
// How it works
// - Opcode 0100 00da rotates the addressed file register right by one with bit 0 moving into bit 7.
// - The right rotate updates only the negative and zero flags and keeps carry, overflow and digit carry.
// - Destination bit 0 sends the result to W and destination bit 1 writes it back to the file register.
// - Access bit 0 addresses the access bank ignoring the bank select register, access bit 1 uses that register.
// - Access bit 0 with the extended set enabled and address at most 95 uses indexed literal offset addressing.
// - Opcode 0110 100a writes FFh into the addressed file register and leaves all flags alone.
// - Sleep clears the watchdog count and its postscaler.
// - Sleep sets the time-out status bit and clears the power-down status bit.
// - After the fourth phase of a sleep the unit enters sleep mode with the oscillator stopped.
// - A wake-up caused by the watchdog clears the time-out status bit.
// - Subtract with borrow computes W minus file minus inverted carry and writes the chosen destination.
`timescale 1ns/1ps
module rot_set_sleep_sub_exec
	import exec_pkg::*;
(
	// Clock and reset.
	input  wire logic                clk_sys_in,
	input  wire logic                resetn_in,
	// Instruction fetch.
	input  wire logic [15:0]         opcode_in,
	input  wire logic                opcode_valid_in,
	// Addressing configuration.
	input  wire logic [BANK_W-1:0]   bank_select_register_in,
	input  wire logic [ADDR_W-1:0]   index_base_in,
	input  wire logic                ext_set_en_in,
	// Wake sources from outside the clock domain.
	input  wire logic                wake_in,
	input  wire logic                wdt_wake_in,
	// Data memory.
	input  wire logic [DATA_W-1:0]   mem_rd_data_in,
	output logic      [ADDR_W-1:0]   mem_addr_out,
	output logic                     mem_wr_en_out,
	output logic      [DATA_W-1:0]   mem_wr_data_out,
	// Core state.
	output logic      [DATA_W-1:0]   w_out,
	output status_type               status_out,
	output logic                     timeout_status_bit_out,
	output logic                     power_down_status_bit_out,
	output logic                     wdt_clear_out,
	output logic                     sleep_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Wake synchronisers.

	logic [1:0] wake_sync_r;
	logic [1:0] wake_sync_nxt;
	logic [1:0] wdt_sync_r;
	logic [1:0] wdt_sync_nxt;
	logic       wake_s;
	logic       wdt_wake_s;

	always_comb
	begin
		wake_sync_nxt = {wake_sync_r[0], wake_in};
		wdt_sync_nxt  = {wdt_sync_r[0], wdt_wake_in};
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			wake_sync_r <= 2'h0;
			wdt_sync_r  <= 2'h0;
		end
		else
		begin
			wake_sync_r <= wake_sync_nxt;
			wdt_sync_r  <= wdt_sync_nxt;
		end
	end

	assign wake_s     = wake_sync_r[1];
	assign wdt_wake_s = wdt_sync_r[1];

	////////////////////////////////////////////////////////////////////////////////
	// Decode.

	function automatic op_type decode(input logic [15:0] op);
		op_type kind;
		kind = OP_NONE;
		if (op[15:10] == ROT_RIGHT_CODE)
			kind = OP_ROT;
		else if (op[15:9] == SET_ONES_CODE)
			kind = OP_SET_FILE_ALL_ONES_OP;
		else if (op == SLEEP_CODE)
			kind = OP_SLEEP;
		else if (op[15:10] == SUB_FWB_CODE)
			kind = OP_SUB_FILE_FROM_W_BORROW_OP;
		else if (op[15:8] == SUB_LW_CODE)
			kind = OP_SUB_W_FROM_LITERAL_OP;
		else if (op[15:10] == SUB_WF_CODE)
			kind = OP_SUB_W_FROM_FILE_OP;
		return kind;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Execution state.

	phase_type             phase_r;
	phase_type             phase_nxt;
	op_type                op_r;
	op_type                op_nxt;
	logic [15:0]           instr_r;
	logic [15:0]           instr_nxt;
	logic [ADDR_W-1:0]     addr_r;
	logic [ADDR_W-1:0]     addr_nxt;
	logic [DATA_W-1:0]     opnd_r;
	logic [DATA_W-1:0]     opnd_nxt;
	logic [DATA_W-1:0]     res_r;
	logic [DATA_W-1:0]     res_nxt;
	status_type            flags_r;
	status_type            flags_nxt;
	logic                  we_r;
	logic                  we_nxt;
	logic                  ww_r;
	logic                  ww_nxt;
	logic [DATA_W-1:0]     w_r;
	logic [DATA_W-1:0]     w_nxt;
	status_type            status_r;
	status_type            status_nxt;
	logic                  to_r;
	logic                  to_nxt;
	logic                  pd_r;
	logic                  pd_nxt;
	logic                  wdtclr_r;
	logic                  wdtclr_nxt;
	logic                  sleep_r;
	logic                  sleep_nxt;

	always_comb
	begin
		logic [7:0] fa;
		logic [7:0] sa;
		logic [7:0] sb;
		logic       cin;
		logic [8:0] sum9;
		logic [4:0] nib5;
		fa = opcode_in[7:0];
		sa = ZERO_BYTE;
		sb = ZERO_BYTE;
		cin = 1'b1;
		sum9 = 9'h000;
		nib5 = 5'h00;
		phase_nxt = phase_r;
		op_nxt = op_r;
		instr_nxt = instr_r;
		addr_nxt = addr_r;
		opnd_nxt = opnd_r;
		res_nxt = res_r;
		flags_nxt = flags_r;
		we_nxt = 1'b0;
		ww_nxt = ww_r;
		w_nxt = w_r;
		status_nxt = status_r;
		to_nxt = to_r;
		pd_nxt = pd_r;
		wdtclr_nxt = 1'b0;
		sleep_nxt = sleep_r;
		// Subtract operands: a minus b minus borrow, borrow being the inverted carry.
		case (op_r)
			OP_SUB_FILE_FROM_W_BORROW_OP:
			begin
				sa = w_r;
				sb = opnd_r;
				cin = status_r.c;
			end
			OP_SUB_W_FROM_LITERAL_OP:
			begin
				sa = instr_r[7:0];
				sb = w_r;
			end
			OP_SUB_W_FROM_FILE_OP:
			begin
				sa = opnd_r;
				sb = w_r;
			end
			default:
			begin
				sa = ZERO_BYTE;
				sb = ZERO_BYTE;
			end
		endcase
		sum9 = {1'b0, sa} + {1'b0, ~sb} + {8'h00, cin};
		nib5 = {1'b0, sa[3:0]} + {1'b0, ~sb[3:0]} + {4'h0, cin};
		if (sleep_r)
		begin
			// The oscillator is stopped, only the wake logic looks on.
			if (wdt_wake_s)
				to_nxt = 1'b0;
			if (wake_s || wdt_wake_s)
				sleep_nxt = 1'b0;
		end
		else
		begin
			case (phase_r)
				PH_Q1:
				begin
					instr_nxt = opcode_valid_in ? opcode_in : NOP_CODE;
					op_nxt = decode(instr_nxt);
					if (opcode_in[ACCESS_BIT])
						addr_nxt = {bank_select_register_in, fa};
					else if (ext_set_en_in && fa <= INDEX_LIMIT)
						addr_nxt = index_base_in + {4'h0, fa};
					else if (fa < ACCESS_SPLIT)
						addr_nxt = {ACCESS_LO_BANK, fa};
					else
						addr_nxt = {ACCESS_HI_BANK, fa};
					phase_nxt = PH_Q2;
				end
				PH_Q2:
				begin
					opnd_nxt = mem_rd_data_in;
					phase_nxt = PH_Q3;
				end
				PH_Q3:
				begin
					flags_nxt = status_r;
					ww_nxt = 1'b0;
					case (op_r)
						OP_ROT:
						begin
							res_nxt = {opnd_r[0], opnd_r[7:1]};
							flags_nxt.n = opnd_r[0];
							flags_nxt.z = (opnd_r == ZERO_BYTE);
							we_nxt = instr_r[DEST_BIT];
							ww_nxt = !instr_r[DEST_BIT];
						end
						OP_SET_FILE_ALL_ONES_OP:
						begin
							res_nxt = ALL_ONES;
							we_nxt = 1'b1;
						end
						OP_SLEEP:
							wdtclr_nxt = 1'b1;
						OP_SUB_FILE_FROM_W_BORROW_OP, OP_SUB_W_FROM_LITERAL_OP, OP_SUB_W_FROM_FILE_OP:
						begin
							res_nxt = sum9[7:0];
							flags_nxt.c = sum9[8];
							flags_nxt.dc = nib5[4];
							flags_nxt.n = sum9[7];
							flags_nxt.z = (sum9[7:0] == ZERO_BYTE);
							flags_nxt.ov = (sa[7] != sb[7]) && (sum9[7] != sa[7]);
							we_nxt = (op_r != OP_SUB_W_FROM_LITERAL_OP) && instr_r[DEST_BIT];
							ww_nxt = (op_r == OP_SUB_W_FROM_LITERAL_OP) || !instr_r[DEST_BIT];
						end
						default:
							res_nxt = res_r;
					endcase
					phase_nxt = PH_Q4;
				end
				PH_Q4:
				begin
					if (ww_r)
						w_nxt = res_r;
					status_nxt = flags_r;
					if (op_r == OP_SLEEP)
					begin
						to_nxt = 1'b1;
						pd_nxt = 1'b0;
						sleep_nxt = 1'b1;
					end
					phase_nxt = PH_Q1;
				end
				default:
					phase_nxt = PH_Q1;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			phase_r <= PH_Q1;
			op_r <= OP_NONE;
			instr_r <= NOP_CODE;
			addr_r <= ADDR_RESET;
			opnd_r <= ZERO_BYTE;
			res_r <= ZERO_BYTE;
			flags_r <= STATUS_RESET;
			we_r <= 1'b0;
			ww_r <= 1'b0;
			w_r <= W_RESET;
			status_r <= STATUS_RESET;
			to_r <= TIMEOUT_RESET;
			pd_r <= PD_RESET;
			wdtclr_r <= 1'b0;
			sleep_r <= 1'b0;
		end
		else
		begin
			phase_r <= phase_nxt;
			op_r <= op_nxt;
			instr_r <= instr_nxt;
			addr_r <= addr_nxt;
			opnd_r <= opnd_nxt;
			res_r <= res_nxt;
			flags_r <= flags_nxt;
			we_r <= we_nxt;
			ww_r <= ww_nxt;
			w_r <= w_nxt;
			status_r <= status_nxt;
			to_r <= to_nxt;
			pd_r <= pd_nxt;
			wdtclr_r <= wdtclr_nxt;
			sleep_r <= sleep_nxt;
		end
	end

	assign mem_addr_out = addr_r;
	assign mem_wr_en_out = we_r;
	assign mem_wr_data_out = res_r;
	assign w_out = w_r;
	assign status_out = status_r;
	assign timeout_status_bit_out = to_r;
	assign power_down_status_bit_out = pd_r;
	assign wdt_clear_out = wdtclr_r;
	assign sleep_out = sleep_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	rot_value_a: assert property (phase_r == PH_Q4 && op_r == OP_ROT |-> res_r == {opnd_r[0], opnd_r[7:1]})
		else $error("rotate result wrong");
	rot_flags_a: assert property (phase_r == PH_Q4 && op_r == OP_ROT |=>
		status_r.c == $past(status_r.c) && status_r.ov == $past(status_r.ov) &&
		status_r.dc == $past(status_r.dc) && status_r.z == ($past(res_r) == ZERO_BYTE))
		else $error("rotate flags wrong");
	dest_file_a: assert property (phase_r == PH_Q4 && op_r == OP_SUB_W_FROM_FILE_OP && instr_r[DEST_BIT]
		|-> mem_wr_en_out ##1 w_out == $past(w_out))
		else $error("file destination not written");
	dest_w_a: assert property (phase_r == PH_Q4 && op_r == OP_ROT && !instr_r[DEST_BIT]
		|-> !mem_wr_en_out ##1 w_out == $past(mem_wr_data_out))
		else $error("W destination not written");
	bank_select_a: assert property (phase_r == PH_Q2 && instr_r[ACCESS_BIT] && op_r != OP_NONE
		|-> mem_addr_out == {$past(bank_select_register_in), instr_r[7:0]})
		else $error("banked address wrong");
	indexed_addr_a: assert property (phase_r == PH_Q2 && !instr_r[ACCESS_BIT] && op_r == OP_SET_FILE_ALL_ONES_OP &&
		$past(ext_set_en_in) && instr_r[7:0] <= INDEX_LIMIT
		|-> mem_addr_out == $past(index_base_in) + {4'h0, instr_r[7:0]})
		else $error("indexed address wrong");
	set_ones_a: assert property (phase_r == PH_Q4 && op_r == OP_SET_FILE_ALL_ONES_OP
		|-> mem_wr_en_out && mem_wr_data_out == ALL_ONES ##1 status_out == $past(status_out))
		else $error("set all ones wrong");
	sleep_entry_a: assert property (phase_r == PH_Q4 && op_r == OP_SLEEP
		|-> wdt_clear_out ##1 sleep_out && timeout_status_bit_out && !power_down_status_bit_out)
		else $error("sleep entry wrong");
	wdt_wake_a: assert property (sleep_r && wdt_wake_s |=> !timeout_status_bit_out && !sleep_out)
		else $error("watchdog wake did not clear time-out");
	sub_borrow_a: assert property (phase_r == PH_Q4 && op_r == OP_SUB_FILE_FROM_W_BORROW_OP
		|-> res_r == 8'(w_r - opnd_r - {7'h00, ~status_r.c}))
		else $error("borrow subtract wrong");
	sub_carry_a: assert property (phase_r == PH_Q4 && op_r == OP_SUB_W_FROM_FILE_OP
		|=> status_r.c == ($past(opnd_r) >= $past(w_r)) && status_r.n == $past(res_r[7]))
		else $error("subtract carry wrong");
	sub_literal_a: assert property (phase_r == PH_Q4 && op_r == OP_SUB_W_FROM_LITERAL_OP
		|-> res_r == 8'(instr_r[7:0] - w_r) ##1 w_out == $past(res_r))
		else $error("literal subtract wrong");

	rot_seen_c: cover property (phase_r == PH_Q4 && op_r == OP_ROT);
	sub_neg_c: cover property (phase_r == PH_Q4 && op_r == OP_SUB_W_FROM_FILE_OP && !flags_r.c);
	sleep_wake_c: cover property (sleep_r ##1 !sleep_r);
endmodule

// ===== test/data_mem_model.sv
// Banked data memory model answering the execution unit's reads and writes.
`timescale 1ns/1ps
module data_mem_model
	import exec_pkg::*;
(
	// Clock.
	input  wire logic              clk_sys_in,
	// Access from the execution unit.
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic              wr_en_in,
	input  wire logic [DATA_W-1:0] wr_data_in,
	output logic      [DATA_W-1:0] rd_data_out
);
	logic [DATA_W-1:0] mem [0:4095];

	// Reads answer at once so the byte is settled before the read phase ends.
	assign rd_data_out = mem[addr_in];

	always @(posedge clk_sys_in)
	begin
		if (wr_en_in)
		begin
			mem[addr_in] <= wr_data_in;
		end
	end
endmodule

// ===== test/tb.sv
// Self-checking testbench for the rotate, set, sleep and subtract execution unit.
`timescale 1ns/1ps
module tb
	import exec_pkg::*;
;
	logic              clk_sys_in = 1'b0;
	logic              resetn_in = 1'b0;
	logic [15:0]       opcode_in = NOP_CODE;
	logic              opcode_valid_in = 1'b0;
	logic [BANK_W-1:0] bank_select_register_in = 4'h0;
	logic [ADDR_W-1:0] index_base_in = 12'h000;
	logic              ext_set_en_in = 1'b0;
	logic              wake_in = 1'b0;
	logic              wdt_wake_in = 1'b0;
	wire logic [7:0]   mem_rd_data;
	logic [ADDR_W-1:0] mem_addr_out;
	logic              mem_wr_en_out;
	logic [7:0]        mem_wr_data_out;
	logic [7:0]        w_out;
	status_type        status_out;
	logic              timeout_status_bit_out;
	logic              power_down_status_bit_out;
	logic              wdt_clear_out;
	logic              sleep_out;
	logic [ADDR_W-1:0] cap_addr;
	logic [7:0]        cap_wd;
	logic [7:0]        cap_w;
	logic [7:0]        w_exp;
	logic [7:0]        r;
	logic              cap_we;
	logic              cap_clr;
	logic              cap_to;
	logic              cap_pd;
	logic              cap_sl;
	status_type        cap_st;
	status_type        st_exp;
	int                err_total = 0;
	int                cmp_count = 0;
	int                cyc = 0;

	////////////////////////////////////////////////////////////////////////////////
	rot_set_sleep_sub_exec dut (
		.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .opcode_in(opcode_in),
		.opcode_valid_in(opcode_valid_in), .bank_select_register_in(bank_select_register_in),
		.index_base_in(index_base_in), .ext_set_en_in(ext_set_en_in), .wake_in(wake_in),
		.wdt_wake_in(wdt_wake_in), .mem_rd_data_in(mem_rd_data), .mem_addr_out(mem_addr_out),
		.mem_wr_en_out(mem_wr_en_out), .mem_wr_data_out(mem_wr_data_out), .w_out(w_out),
		.status_out(status_out), .timeout_status_bit_out(timeout_status_bit_out),
		.power_down_status_bit_out(power_down_status_bit_out), .wdt_clear_out(wdt_clear_out),
		.sleep_out(sleep_out));

	data_mem_model mem_model (
		.clk_sys_in(clk_sys_in), .addr_in(mem_addr_out), .wr_en_in(mem_wr_en_out),
		.wr_data_in(mem_wr_data_out), .rd_data_out(mem_rd_data));

	always #10 clk_sys_in = ~clk_sys_in;

	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clk_sys_in)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			err_total++;
			stop_test();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Expected difference a - b - borrow, with carry meaning no borrow.
	task automatic do_sub(input logic [7:0] a, input logic [7:0] b, input logic cin);
		logic [8:0] full;
		logic [4:0] lo;
		full = {1'b0, a} - {1'b0, b} - {8'h00, ~cin};
		lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
		r = full[7:0];
		st_exp.c = ~full[8];
		st_exp.dc = ~lo[4];
		st_exp.z = (r == 8'h00);
		st_exp.n = r[7];
		st_exp.ov = (a[7] != b[7]) && (r[7] != a[7]);
	endtask

	// Runs the instruction sampled at the next edge, then a no-op, capturing results.
	task automatic finish_op();
		repeat (3) @(posedge clk_sys_in);
		#1;
		cap_we = mem_wr_en_out;
		cap_wd = mem_wr_data_out;
		cap_addr = mem_addr_out;
		cap_clr = wdt_clear_out;
		@(posedge clk_sys_in);
		opcode_valid_in <= 1'b0;
		wake_in <= 1'b0;
		wdt_wake_in <= 1'b0;
		@(negedge clk_sys_in);
		cap_w = w_out;
		cap_st = status_out;
		cap_to = timeout_status_bit_out;
		cap_pd = power_down_status_bit_out;
		cap_sl = sleep_out;
		repeat (4) @(posedge clk_sys_in);
	endtask

	task automatic exec(input logic [15:0] op);
		opcode_in <= op;
		opcode_valid_in <= 1'b1;
		finish_op();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		mem_model.mem[12'h010] = 8'h01;
		mem_model.mem[12'h345] = 8'h01;
		mem_model.mem[12'hF70] = 8'hD7;
		mem_model.mem[12'h205] = 8'h01;
		w_exp = 8'h00;
		st_exp = STATUS_RESET;
		repeat (16) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		do_sub(8'h02, w_exp, 1'b1);
		exec({SUB_LW_CODE, 8'h02});
		w_exp = r;
		chk(16'(cap_w), 16'(w_exp));
		chk(16'(cap_st), 16'(st_exp));
		chk(16'(cap_we), 16'h0000);
		do_sub(8'h01, w_exp, 1'b1);
		exec({SUB_WF_CODE, 1'b1, 1'b0, 8'h10});
		chk(16'(cap_addr), 16'h0010);
		chk(16'(cap_we), 16'h0001);
		chk(16'(cap_wd), 16'(r));
		chk(16'(cap_st), 16'(st_exp));
		bank_select_register_in <= 4'h3;
		do_sub(w_exp, 8'h01, st_exp.c);
		exec({SUB_FWB_CODE, 1'b0, 1'b1, 8'h45});
		w_exp = r;
		chk(16'(cap_addr), 16'h0345);
		chk(16'(cap_we), 16'h0000);
		chk(16'(cap_w), 16'(w_exp));
		chk(16'(cap_st), 16'(st_exp));
		exec({ROT_RIGHT_CODE, 1'b1, 1'b0, 8'h70});
		st_exp.n = 1'b1;
		st_exp.z = 1'b0;
		chk(16'(cap_addr), 16'h0F70);
		chk(16'(cap_wd), 16'h00EB);
		chk(16'(cap_st), 16'(st_exp));
		ext_set_en_in <= 1'b1;
		index_base_in <= 12'h200;
		exec({ROT_RIGHT_CODE, 1'b0, 1'b0, 8'h05});
		w_exp = 8'h80;
		chk(16'(cap_addr), 16'h0205);
		chk(16'(cap_w), 16'(w_exp));
		chk(16'(cap_we), 16'h0000);
		chk(16'(cap_st), 16'(st_exp));
		for (int i = 0; i < 2; i++)
		begin
			exec({SET_ONES_CODE, 1'b0, 8'h5F + 8'(i)});
			chk(16'(cap_addr), (i == 0) ? 16'h025F : 16'h0F60);
			chk(16'(cap_wd), 16'h00FF);
			chk(16'(cap_st), 16'(st_exp));
		end
		do_sub(8'h7F, w_exp, 1'b1);
		exec({SUB_LW_CODE, 8'h7F});
		w_exp = r;
		chk(16'(cap_w), 16'(w_exp));
		chk(16'(cap_st), 16'(st_exp));
		// Borrow subtract back into a banked file register, then subtract into W through the index base.
		do_sub(w_exp, 8'h01, st_exp.c);
		exec({SUB_FWB_CODE, 1'b1, 1'b1, 8'h45});
		chk(16'(cap_addr), 16'h0345);
		chk(16'(cap_we), 16'h0001);
		chk(16'(cap_wd), 16'(r));
		chk(16'(cap_clr), 16'h0000);
		chk(16'(cap_w), 16'(w_exp));
		chk(16'(cap_st), 16'(st_exp));
		do_sub(8'h01, w_exp, 1'b1);
		exec({SUB_WF_CODE, 1'b0, 1'b0, 8'h05});
		w_exp = r;
		chk(16'(cap_addr), 16'h0205);
		chk(16'(cap_we), 16'h0000);
		chk(16'(cap_w), 16'(w_exp));
		chk(16'(cap_st), 16'(st_exp));
		for (int src = 0; src < 2; src++)
		begin
			exec(SLEEP_CODE);
			chk(16'(cap_clr), 16'h0001);
			chk(16'(cap_sl), 16'h0001);
			chk(16'({cap_to, cap_pd}), 16'h0002);
			// The next opcode is presented while asleep and must only run after the wake-up.
			opcode_in <= {SUB_LW_CODE, 8'h05};
			opcode_valid_in <= 1'b1;
			if (src == 1)
				wdt_wake_in <= 1'b1;
			else
				wake_in <= 1'b1;
			for (int k = 0; k < 20; k++)
			begin
				@(posedge clk_sys_in);
				#1;
				if (sleep_out === 1'b0)
					break;
			end
			chk(16'(sleep_out), 16'h0000);
			do_sub(8'h05, w_exp, 1'b1);
			finish_op();
			w_exp = r;
			chk(16'(cap_w), 16'(w_exp));
			chk(16'(cap_to), (src == 1) ? 16'h0000 : 16'h0001);
		end
		stop_test();
	end
endmodule
